// ==== design/pcsr_pkg.sv ====
// Purpose: Constants for the pad configuration and link status registers
// Assumes: 8-bit register port, one 20 MHz clock
// Notes: Offsets are byte addresses on the plain register port

// ----------------------------------------------------------------
// Package
// ----------------------------------------------------------------
package pcsr_pkg;

	// Register port widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFS_GLOBAL_PAD9 = 8'h1A;
	localparam logic [7:0] OFS_FREQ_MEASURE = 8'h1B;
	localparam logic [7:0] OFS_LINK_STATUS = 8'h1C;
	localparam logic [7:0] OFS_PAD0_CONFIG = 8'h1D;
	localparam logic [7:0] OFS_PAD1_PAD2 = 8'h1E;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h31;
	localparam logic [7:0] OFS_PORT_CTRL = 8'h32;
	localparam logic [7:0] OFS_PAD_LEVEL = 8'h33;

	// Global and pad 9 field positions
	localparam int GLB_OUT_BIT = 7;
	localparam int GLB_DIR_BIT = 5;
	localparam int GLB_EN_BIT = 4;
	localparam int P9_OUT_BIT = 3;
	localparam int P9_DIR_BIT = 1;
	localparam int P9_EN_BIT = 0;

	// Pad 0 field positions; revision sits in the top nibble
	localparam int P0_REV_LSB = 4;
	localparam int P0_OUT_BIT = 3;
	localparam int P0_REM_BIT = 2;
	localparam int P0_DIR_BIT = 1;
	localparam int P0_EN_BIT = 0;
	localparam logic [7:0] P0_WR_MASK = 8'h0F;

	// Status field positions
	localparam int ST_DUAL_BIT = 4;
	localparam int ST_AUDIO_BIT = 3;
	localparam int ST_LOCK_BIT = 0;

	// Interrupt event positions
	localparam int EV_MEAS_DONE = 0;
	localparam int EV_LOCK_CHG = 1;
	localparam int EV_AUDIO_CHG = 2;
	localparam logic [7:0] EV_MASK = 8'h07;

	// Port control field
	localparam int PC_SECOND_PORT_BIT = 0;

	// Reset values
	localparam logic [7:0] RST_REG = 8'h00;

	// Timing: oscillator tick and system clock period in ns
	localparam int OSC_PERIOD_NS = 40;
	localparam int CLK_FREQ_HZ = 20_000_000;
	localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_FREQ_HZ;
	localparam logic [15:0] CLK_STEP_NS = 16'(CLK_PERIOD_NS);
	localparam logic [7:0] OSC_MULT = 8'(OSC_PERIOD_NS);

	// Pad mode from the {direction, enable} pair
	typedef enum logic [1:0] {
		PCSR_FUNC_OUT,
		PCSR_TRISTATE,
		PCSR_GP_OUT,
		PCSR_GP_IN
	} pcsr_pad_mode_type;

endpackage : pcsr_pkg

// ==== design/pcsr_regs.sv ====
// Purpose: Pad configuration, pixel clock measure and link status regs
// Assumes: Pixel clock below a quarter of ref_clk_in, sampled as a pin
// Notes: Read data is registered and valid the cycle after the strobe
`timescale 1ns/1ps

module pcsr_regs #(
	// Arbitrary revision value, not tied to any part
	parameter logic [3:0] SILICON_REVISION = 4'hA,
	parameter int COUNT_W = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [pcsr_pkg::ADDR_W-1:0] addr_in,
	input wire logic [pcsr_pkg::DATA_W-1:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	output logic [pcsr_pkg::DATA_W-1:0] rd_data_out,
	output logic irq_out,
	input wire logic pix_clk_in,
	input wire logic lock_ch0_in,
	input wire logic lock_ch1_in,
	input wire logic dual_link_in,
	input wire logic audio_lock_in,
	input wire logic func_pad0_value_in,
	input wire logic func_sp_pad0_value_in,
	input wire logic func_pad9_value_in,
	input wire logic remote_pad0_value_in,
	input wire logic pad0_in,
	output logic pad0_out,
	output logic pad0_oe_out,
	input wire logic second_port_pad0_in,
	output logic second_port_pad0_out,
	output logic second_port_pad0_oe_out,
	input wire logic pad9_in,
	output logic pad9_out,
	output logic pad9_oe_out
);
	import pcsr_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Mode from a {direction, enable} pair
	function automatic pcsr_pad_mode_type decode_mode(input logic dir,
		input logic en);
		pcsr_pad_mode_type m;
		m = PCSR_FUNC_OUT;
		case ({dir, en})
			2'b00: m = PCSR_FUNC_OUT;
			2'b10: m = PCSR_TRISTATE;
			2'b01: m = PCSR_GP_OUT;
			default: m = PCSR_GP_IN;
		endcase
		return m;
	endfunction : decode_mode

	// Resolve one pad to {output enable, value}
	function automatic logic [1:0] resolve_pad(input logic ind_dir,
		input logic ind_en, input logic loc_val, input logic rem_en,
		input logic rem_val, input logic func_val, input logic g_dir,
		input logic g_en, input logic g_val);
		logic [1:0] r;
		pcsr_pad_mode_type m;
		r = 2'b00;
		m = PCSR_FUNC_OUT;
		if (rem_en) begin
			r = {1'b1, rem_val};
		end else if (ind_dir || ind_en) begin
			m = decode_mode(ind_dir, ind_en);
			case (m)
				PCSR_FUNC_OUT: r = {1'b1, func_val};
				PCSR_GP_OUT: r = {1'b1, loc_val};
				default: r = 2'b00;
			endcase
		end else begin
			m = decode_mode(g_dir, g_en);
			case (m)
				PCSR_FUNC_OUT: r = {1'b1, func_val};
				PCSR_GP_OUT: r = {1'b1, g_val};
				default: r = 2'b00;
			endcase
		end
		return r;
	endfunction : resolve_pad

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------

	// Bit order of the synchronised pin group
	localparam int S_PIX = 0;
	localparam int S_LOCK0 = 1;
	localparam int S_LOCK1 = 2;
	localparam int S_DUAL = 3;
	localparam int S_AUDIO = 4;
	localparam int S_PAD0 = 5;
	localparam int S_SPPAD0 = 6;
	localparam int S_PAD9 = 7;

	logic [7:0] pins_raw;
	logic [7:0] sync_meta;
	logic [7:0] sync_pins;
	logic pix_prev;

	assign pins_raw = {pad9_in, second_port_pad0_in, pad0_in,
		audio_lock_in, dual_link_in, lock_ch1_in, lock_ch0_in, pix_clk_in};

	// Two stages; only the second stage feeds logic
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sync_meta <= 8'h00;
			sync_pins <= 8'h00;
			pix_prev <= 1'b0;
		end else begin
			sync_meta <= pins_raw;
			sync_pins <= sync_meta;
			pix_prev <= sync_pins[S_PIX];
		end
	end

	// ----------------------------------------------------------------
	// Register storage and bus decode
	// ----------------------------------------------------------------

	logic [7:0] global_and_pad9_config;
	logic [3:0] pad0_config;
	logic [7:0] pad1_pad2_config;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic second_port_select;

	wire wr_global = wr_strobe_in && (addr_in == OFS_GLOBAL_PAD9);
	wire wr_freq = wr_strobe_in && (addr_in == OFS_FREQ_MEASURE);
	wire wr_pad0 = wr_strobe_in && (addr_in == OFS_PAD0_CONFIG);
	wire wr_pad12 = wr_strobe_in && (addr_in == OFS_PAD1_PAD2);
	wire wr_istat = wr_strobe_in && (addr_in == OFS_IRQ_STATUS);
	wire wr_imask = wr_strobe_in && (addr_in == OFS_IRQ_MASK);
	wire wr_pctrl = wr_strobe_in && (addr_in == OFS_PORT_CTRL);

	// Configuration registers; reserved bits of the global byte store
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			global_and_pad9_config <= RST_REG;
			pad0_config <= 4'h0;
			pad1_pad2_config <= RST_REG;
			irq_mask <= RST_REG;
			second_port_select <= 1'b0;
		end else begin
			if (wr_global)
				global_and_pad9_config <= wr_data_in;
			if (wr_pad0)
				pad0_config <= wr_data_in[3:0] & P0_WR_MASK[3:0];
			if (wr_pad12)
				pad1_pad2_config <= wr_data_in;
			if (wr_imask)
				irq_mask <= wr_data_in & EV_MASK;
			if (wr_pctrl)
				second_port_select <= wr_data_in[PC_SECOND_PORT_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Link status
	// ----------------------------------------------------------------

	logic link_lock_now;
	logic link_lock;
	logic audio_lock;
	logic dual_link;

	assign link_lock_now = sync_pins[S_DUAL] ?
		(sync_pins[S_LOCK0] && sync_pins[S_LOCK1]) : sync_pins[S_LOCK0];

	// Status flags held one stage so changes can raise events
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			link_lock <= 1'b0;
			audio_lock <= 1'b0;
			dual_link <= 1'b0;
		end else begin
			link_lock <= link_lock_now;
			audio_lock <= sync_pins[S_AUDIO];
			dual_link <= sync_pins[S_DUAL];
		end
	end

	// ----------------------------------------------------------------
	// Pixel clock frequency measurement
	// ----------------------------------------------------------------

	logic [COUNT_W-1:0] pix_count;
	logic [15:0] meas_target_ns;
	logic [15:0] meas_elapsed_ns;
	logic meas_busy;
	logic meas_done;
	wire pix_edge = sync_pins[S_PIX] && !pix_prev;
	wire [15:0] next_elapsed_ns = meas_elapsed_ns + CLK_STEP_NS;
	wire count_full = &pix_count;
	wire [15:0] wr_target_ns = 16'(wr_data_in) * 16'(OSC_MULT);

	// Elapsed time is kept in ns so the 40 ns tick needs no second clock
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pix_count <= '0;
			meas_target_ns <= 16'h0000;
			meas_elapsed_ns <= 16'h0000;
			meas_busy <= 1'b0;
			meas_done <= 1'b0;
		end else begin
			meas_done <= 1'b0;
			if (wr_freq) begin
				pix_count <= '0;
				meas_target_ns <= wr_target_ns;
				meas_elapsed_ns <= 16'h0000;
				meas_busy <= (wr_data_in != 8'h00);
				meas_done <= (wr_data_in == 8'h00);
			end else if (meas_busy) begin
				if (pix_edge && !count_full)
					pix_count <= pix_count + 1'b1;
				meas_elapsed_ns <= next_elapsed_ns;
				if (next_elapsed_ns >= meas_target_ns) begin
					meas_busy <= 1'b0;
					meas_done <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status and output
	// ----------------------------------------------------------------

	logic [7:0] events;
	logic audio_prev_valid;

	assign events = {5'b00000,
		(audio_lock != sync_pins[S_AUDIO]) && audio_prev_valid,
		(link_lock != link_lock_now) && audio_prev_valid,
		meas_done};

	// Set wins over a same-cycle write-one-to-clear
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			irq_status <= RST_REG;
			irq_out <= 1'b0;
			audio_prev_valid <= 1'b0;
		end else begin
			audio_prev_valid <= 1'b1;
			irq_status <= ((wr_istat ? (irq_status & ~wr_data_in) :
				irq_status) | events) & EV_MASK;
			irq_out <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Pad control
	// ----------------------------------------------------------------

	wire g_dir = global_and_pad9_config[GLB_DIR_BIT];
	wire g_en = global_and_pad9_config[GLB_EN_BIT];
	wire g_val = global_and_pad9_config[GLB_OUT_BIT];
	logic [1:0] next_pad9;
	logic [1:0] cfg_pad0;
	logic [1:0] glob_pad0;
	logic [1:0] glob_sp_pad0;
	logic [1:0] next_pad0;
	logic [1:0] next_sp_pad0;

	assign next_pad9 = resolve_pad(global_and_pad9_config[P9_DIR_BIT],
		global_and_pad9_config[P9_EN_BIT],
		global_and_pad9_config[P9_OUT_BIT], 1'b0, 1'b0,
		func_pad9_value_in, g_dir, g_en, g_val);

	assign cfg_pad0 = resolve_pad(pad0_config[P0_DIR_BIT],
		pad0_config[P0_EN_BIT], pad0_config[P0_OUT_BIT],
		pad0_config[P0_REM_BIT], remote_pad0_value_in,
		second_port_select ? func_sp_pad0_value_in : func_pad0_value_in,
		g_dir, g_en, g_val);

	// Unselected pad follows only the global setting
	assign glob_pad0 = resolve_pad(1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		func_pad0_value_in, g_dir, g_en, g_val);
	assign glob_sp_pad0 = resolve_pad(1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
		func_sp_pad0_value_in, g_dir, g_en, g_val);

	assign next_pad0 = second_port_select ? glob_pad0 : cfg_pad0;
	assign next_sp_pad0 = second_port_select ? cfg_pad0 : glob_sp_pad0;

	// Registered pad drivers; one cycle of latency after a config write
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pad9_oe_out <= 1'b0;
			pad9_out <= 1'b0;
			pad0_oe_out <= 1'b0;
			pad0_out <= 1'b0;
			second_port_pad0_oe_out <= 1'b0;
			second_port_pad0_out <= 1'b0;
		end else begin
			{pad9_oe_out, pad9_out} <= next_pad9;
			{pad0_oe_out, pad0_out} <= next_pad0;
			{second_port_pad0_oe_out, second_port_pad0_out} <= next_sp_pad0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	logic [7:0] status_byte;
	logic [7:0] pad0_byte;
	logic [7:0] level_byte;
	logic [7:0] next_rd_data;

	assign status_byte = {3'b000, dual_link, audio_lock, 2'b00, link_lock};
	assign pad0_byte = {SILICON_REVISION, pad0_config};
	assign level_byte = {4'h0, meas_busy, sync_pins[S_PAD9],
		sync_pins[S_SPPAD0], sync_pins[S_PAD0]};

	// Unmapped offsets read as zero
	always_comb begin
		next_rd_data = 8'h00;
		if (addr_in == OFS_GLOBAL_PAD9)
			next_rd_data = global_and_pad9_config;
		else if (addr_in == OFS_FREQ_MEASURE)
			next_rd_data = 8'(pix_count);
		else if (addr_in == OFS_LINK_STATUS)
			next_rd_data = status_byte;
		else if (addr_in == OFS_PAD0_CONFIG)
			next_rd_data = pad0_byte;
		else if (addr_in == OFS_PAD1_PAD2)
			next_rd_data = pad1_pad2_config;
		else if (addr_in == OFS_IRQ_STATUS)
			next_rd_data = irq_status;
		else if (addr_in == OFS_IRQ_MASK)
			next_rd_data = irq_mask;
		else if (addr_in == OFS_PORT_CTRL)
			next_rd_data = {7'h00, second_port_select};
		else if (addr_in == OFS_PAD_LEVEL)
			next_rd_data = level_byte;
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			rd_data_out <= 8'h00;
		else if (rd_strobe_in)
			rd_data_out <= next_rd_data;
		else
			rd_data_out <= 8'h00;
	end

endmodule : pcsr_regs

// ==== bench/pcsr_checker.sv ====
// Purpose: Port checker for pcsr_regs
// Assumes: One clock, async active-low reset
// Notes: Pads are checked two cycles after the write that sets them
`timescale 1ns/1ps
module pcsr_checker import pcsr_pkg::*; #(
	parameter logic [3:0] SILICON_REVISION = 4'hA
) (
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	input wire logic [7:0] rd_data_out,
	input wire logic lock_ch0_in,
	input wire logic lock_ch1_in,
	input wire logic dual_link_in,
	input wire logic audio_lock_in,
	input wire logic remote_pad0_value_in,
	input wire logic pad0_out,
	input wire logic pad0_oe_out,
	input wire logic second_port_pad0_out,
	input wire logic second_port_pad0_oe_out,
	input wire logic pad9_out,
	input wire logic pad9_oe_out
);
	// ----------------------------------------
	// Decodes
	// ----------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Write and read selects, and the bits that the pads must copy
	wire logic wr9 = wr_strobe_in && addr_in == OFS_GLOBAL_PAD9;
	wire logic wr0 = wr_strobe_in && addr_in == OFS_PAD0_CONFIG;
	wire logic rds = rd_strobe_in && addr_in == OFS_LINK_STATUS;
	wire logic d3 = wr_data_in[3];
	wire logic d7 = wr_data_in[7];
	wire logic rv = remote_pad0_value_in;
	wire logic [3:0] pins = {lock_ch0_in, lock_ch1_in, dual_link_in,
		audio_lock_in};
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	unmapped_zero_a: assert property (
		rd_strobe_in && addr_in == 8'h40 |=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	status_rsvd_a: assert property (
		rds |=> rd_data_out[7:5] == 3'h0 && rd_data_out[2:1] == 2'h0)
		else $error("reserved status bit set");
	rev_field_a: assert property (
		rd_strobe_in && addr_in == OFS_PAD0_CONFIG
		|=> rd_data_out[7:4] == SILICON_REVISION)
		else $error("revision field wrong");
	// Synchroniser needs three edges, so pins must sit still for five;
	// single-link lock follows channel 0 alone, dual-link needs both
	status_flags_a: assert property (
		$stable(pins)[*5] ##0 rds |=>
		rd_data_out[4] == $past(dual_link_in)
		&& rd_data_out[3] == $past(audio_lock_in)
		&& rd_data_out[0] == ($past(lock_ch0_in)
		&& ($past(lock_ch1_in) || !$past(dual_link_in))))
		else $error("status flags do not follow pins");
	pad9_gp_a: assert property (
		wr9 && wr_data_in[1:0] == 2'b01 ##1 !wr9
		|=> pad9_oe_out && pad9_out == $past(d3, 2))
		else $error("pad9 output wrong");
	pad9_off_a: assert property (
		wr9 && wr_data_in[1] ##1 !wr9 |=> !pad9_oe_out)
		else $error("pad9 driven while released");
	glob_drive_a: assert property (
		wr9 && wr_data_in[5:0] == 6'h10 ##1 !wr9
		|=> pad9_oe_out && pad9_out == $past(d7, 2))
		else $error("global value not driven");
	remote_pad_a: assert property (
		wr0 && wr_data_in[2] ##1 !wr0 |=>
		pad0_oe_out && pad0_out == $past(rv)
		|| second_port_pad0_oe_out && second_port_pad0_out == $past(rv))
		else $error("remote value not on pad0");
endmodule : pcsr_checker

bind pcsr_regs pcsr_checker #(.SILICON_REVISION(SILICON_REVISION))
	pcsr_checker_i (.*);

// ==== bench/pcsr_link_partner.sv ====
// Purpose: Far side: link receiver, remote serializer, pixel source
// Assumes: Bench commands the link state through cfg_in
// Notes: cfg_in is {remote value, audio, dual, lock1, lock0}
`timescale 1ns/1ps
module pcsr_link_partner #(
	parameter int PIX_HALF_NS = 125
) (
	input wire logic ref_clk_in,
	input wire logic [4:0] cfg_in,
	output logic pix_clk_out,
	output logic [4:0] link_out
);
	logic [4:0] state = 5'h00;
	// Pixel source below a quarter of the ref rate, phase unrelated
	initial begin
		pix_clk_out = 1'b0;
		#17;
		forever #(PIX_HALF_NS) pix_clk_out = ~pix_clk_out;
	end
	// Link state moves just after a ref edge, like the real receiver
	always @(posedge ref_clk_in) begin
		state <= cfg_in;
	end
	assign link_out = state;
endmodule : pcsr_link_partner

// ==== bench/testbench.sv ====
// Purpose: Self-checking bench for pcsr_regs
// Assumes: Partner gives link state and a 250 ns pixel clock
// Notes: Released pads float high through a pull-up
`timescale 1ns/1ps
module testbench;
	import pcsr_pkg::*;
	localparam logic [3:0] REV = 4'h5; // Arbitrary revision value
	logic ref_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic fv = 1'b1;
	logic [4:0] cfg = 5'h00;
	wire logic pix, irq, p0, p0e, s0, s0e, p9, p9e;
	wire logic [4:0] lk;
	wire logic [7:0] rdo;
	wire logic [5:0] pads = {p0e, p0e & p0, s0e, s0e & s0, p9e, p9e & p9};
	int n_errors = 0;
	int tests_run = 0;
	always #25 ref_clk_in = ~ref_clk_in;
	pcsr_link_partner pcsr_link_partner_i (.ref_clk_in(ref_clk_in),
		.cfg_in(cfg), .pix_clk_out(pix), .link_out(lk));
	pcsr_regs #(.SILICON_REVISION(REV), .COUNT_W(5)) pcsr_regs_i (
		.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .addr_in(addr),
		.wr_data_in(wdata), .wr_strobe_in(wr), .rd_strobe_in(rd),
		.rd_data_out(rdo), .irq_out(irq), .pix_clk_in(pix),
		.lock_ch0_in(lk[0]), .lock_ch1_in(lk[1]), .dual_link_in(lk[2]),
		.audio_lock_in(lk[3]), .remote_pad0_value_in(lk[4]),
		.func_pad0_value_in(fv), .func_sp_pad0_value_in(~fv),
		.func_pad9_value_in(fv), .pad0_in(p0e ? p0 : 1'b1),
		.pad0_out(p0), .pad0_oe_out(p0e),
		.second_port_pad0_in(s0e ? s0 : 1'b1),
		.second_port_pad0_out(s0), .second_port_pad0_oe_out(s0e),
		.pad9_in(p9e ? p9 : 1'b1), .pad9_out(p9), .pad9_oe_out(p9e));
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] lo, hi, v);
		tests_run++;
		if ((v >= lo && v <= hi) !== 1'b1) begin
			$display("[ERR] %s expected %0h..%0h seen %0h", what, lo, hi, v);
			n_errors++;
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
		@(posedge ref_clk_in);
	endtask : wr_reg
	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input string what, input logic [7:0] a, e);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		#1 chk(what, e, e, rdo);
		@(posedge ref_clk_in);
	endtask : rd_chk
	// Pads settle two edges after the write; out masked by enable
	task automatic pad_chk(input logic [7:0] a, d, input int k, e);
		wr_reg(a, d);
		#1 chk("pad", e, e, pads[2*k +: 2]);
		@(posedge ref_clk_in);
	endtask : pad_chk
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		rd_chk("pad0 cfg", OFS_PAD0_CONFIG, {REV, 4'h0});
		rd_chk("freq", OFS_FREQ_MEASURE, 8'h00);
		rd_chk("status", OFS_LINK_STATUS, 8'h00);
		rd_chk("global", OFS_GLOBAL_PAD9, 8'h00);
		rd_chk("unmapped", 8'h40, 8'h00);
		#1 chk("pad9", 3, 3, pads[1:0]);
		@(posedge ref_clk_in);
		// Each pad must carry its own functional input, not a constant
		fv <= 1'b0;
		@(posedge ref_clk_in);
		#1 chk("func pads", 16'h2E, 16'h2E, pads);
		@(posedge ref_clk_in);
		fv <= 1'b1;
		@(posedge ref_clk_in);
		#1 chk("func pads", 16'h3B, 16'h3B, pads);
		@(posedge ref_clk_in);
	endtask : t_reset
	task automatic t_pads;
		logic [7:0] d[10] = '{8'h00, 8'h01, 8'h09, 8'h02, 8'h03, 8'h90,
			8'h10, 8'h20, 8'h30, 8'h31};
		int e[10] = '{3, 2, 3, 0, 0, 3, 2, 0, 0, 2};
		logic [7:0] q[8] = '{8'h00, 8'h01, 8'h09, 8'h02, 8'h03, 8'h04,
			8'h07, 8'h06};
		int f[8] = '{3, 2, 3, 0, 0, 3, 3, 3};
		for (int i = 0; i < 10; i++) begin
			pad_chk(OFS_GLOBAL_PAD9, d[i], 0, e[i]);
		end
		wr_reg(OFS_GLOBAL_PAD9, 8'h00);
		cfg <= 5'h10;
		for (int i = 0; i < 8; i++) begin
			pad_chk(OFS_PAD0_CONFIG, q[i], 2, f[i]);
		end
		cfg <= 5'h00;
		pad_chk(OFS_PAD0_CONFIG, 8'h0D, 2, 2);
		wr_reg(OFS_PAD0_CONFIG, 8'hFF);
		rd_chk("pad0 cfg", OFS_PAD0_CONFIG, {REV, 4'hF});
		// Pad 0 carries the remote low, second port its functional low
		rd_chk("levels", OFS_PAD_LEVEL, 8'h04);
		wr_reg(OFS_GLOBAL_PAD9, 8'h10);
		wr_reg(OFS_PORT_CTRL, 8'h01);
		pad_chk(OFS_PAD0_CONFIG, 8'h09, 1, 3);
		chk("pad0 global", 2, 2, pads[5:4]);
		pad_chk(OFS_PORT_CTRL, 8'h00, 2, 3);
		chk("sp global", 2, 2, pads[3:2]);
		wr_reg(OFS_GLOBAL_PAD9, 8'h00);
	endtask : t_pads
	task automatic t_status;
		logic [4:0] c[6] = '{5'h00, 5'h09, 5'h06, 5'h07, 5'h0F, 5'h02};
		logic [7:0] e[6] = '{8'h00, 8'h09, 8'h10, 8'h11, 8'h19, 8'h00};
		for (int i = 0; i < 6; i++) begin
			cfg <= c[i];
			repeat (6) @(posedge ref_clk_in);
			rd_chk("status", OFS_LINK_STATUS, e[i]);
		end
		rd_chk("irq status", OFS_IRQ_STATUS, 8'h06);
		wr_reg(OFS_IRQ_STATUS, 8'h07);
		rd_chk("irq status", OFS_IRQ_STATUS, 8'h00);
	endtask : t_status
	// Interval is N x 40 ns, i.e. N x 4 / 5 ref cycles; the count is
	// five bits wide here, so some 40 edges in 10 us must stop at 31
	task automatic t_freq;
		logic [7:0] n[3] = '{8'd25, 8'd250, 8'd0};
		int lo[3] = '{3, 31, 0};
		int hi[3] = '{5, 31, 0};
		int cyc[3] = '{20, 200, 0};
		int k;
		wr_reg(OFS_IRQ_MASK, 8'h01);
		for (int i = 0; i < 3; i++) begin
			wr_reg(OFS_FREQ_MEASURE, n[i]);
			k = 0;
			#1;
			while (irq !== 1'b1 && k < 300) begin
				@(posedge ref_clk_in);
				#1 k++;
			end
			chk("interval", cyc[i], cyc[i] + 2, k);
			@(posedge ref_clk_in);
			rd_chk("done event", OFS_IRQ_STATUS, 8'h01);
			addr <= OFS_FREQ_MEASURE;
			rd <= 1'b1;
			@(posedge ref_clk_in);
			rd <= 1'b0;
			#1 chk("count", lo[i], hi[i], rdo);
			@(posedge ref_clk_in);
			wr_reg(OFS_IRQ_STATUS, 8'h01);
			#1 chk("irq clear", 0, 0, irq);
			@(posedge ref_clk_in);
		end
		wr_reg(OFS_IRQ_MASK, 8'h00);
		wr_reg(OFS_FREQ_MEASURE, 8'd1);
		repeat (10) @(posedge ref_clk_in);
		#1 chk("irq masked", 0, 0, irq);
		@(posedge ref_clk_in);
		rd_chk("irq status", OFS_IRQ_STATUS, 8'h01);
	endtask : t_freq
	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	// Main sequence after a five-cycle reset
	initial begin
		repeat (5) @(posedge ref_clk_in);
		rst_b_in <= 1'b1;
		@(posedge ref_clk_in);
		t_reset();
		t_pads();
		t_status();
		t_freq();
		report_and_stop();
	end
	// Watchdog well beyond the roughly 430 cycles the tests need
	initial begin
		repeat (6000) @(posedge ref_clk_in);
		n_errors++;
		report_and_stop();
	end
endmodule : testbench
